// ### pmb_pkg.sv
// package for the pattern memory board controller
// assumes: included before the interface and both modules
package pmb_pkg;
    // group select on the host address register
    localparam logic [1:0] GRP_CTRL  = 2'h2;
    localparam logic [1:0] GRP_MOD   = 2'h3;
    // group-two offsets
    localparam logic [3:0] OFS_WLOW  = 4'h0;
    localparam logic [3:0] OFS_WMID  = 4'h1;
    localparam logic [3:0] OFS_WHIGH = 4'h2;
    localparam logic [3:0] OFS_RLOW  = 4'h3;
    localparam logic [3:0] OFS_RMID  = 4'h4;
    localparam logic [3:0] OFS_RHIGH = 4'h5;
    localparam logic [3:0] OFS_ALOW  = 4'h6;
    localparam logic [3:0] OFS_AMID  = 4'h7;
    localparam logic [3:0] OFS_AHIGH = 4'h8;
    localparam logic [3:0] OFS_SLOW  = 4'h9;
    localparam logic [3:0] OFS_SMID  = 4'hA;
    localparam logic [3:0] OFS_SHIGH = 4'hB;
    localparam logic [3:0] OFS_PCTRL = 4'hC;
    // group-three offsets
    localparam logic [3:0] OFS_MODLIM = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_CLKSEL = 4'h9;
    // field positions
    localparam int DIR_BIT    = 18;
    localparam int STROBE_BIT = 16;
    localparam int TRANSMIT_ENABLE_PIN_BIT   = 17;
    localparam int PLAY_BIT   = 0;
    // playback end address
    localparam logic [17:0] PATTERN_END = 18'h03FFF;
    // reset values
    localparam logic [1:0]  CLKSEL_RST = 2'h0;
    localparam logic [1:0]  DINSRC_RST = 2'h1;
    // data input bus sources
    typedef enum logic [1:0] {
        DIN_MEMORY = 2'b00,
        DIN_GROUND = 2'b01,
        DIN_HIZ    = 2'b10
    } din_src_t;
    // indirect access sequencer
    typedef enum logic [1:0] {
        ACC_IDLE  = 2'b00,
        ACC_ISSUE = 2'b01,
        ACC_WAIT  = 2'b10,
        ACC_GRAB  = 2'b11
    } acc_state_t;
endpackage

// ### sram_if.sv
// interface between register front end and sram sequencer
// assumes: both ends on sample_data_clock
`timescale 1ns/1ps
`default_nettype none
interface sram_if;
    logic        start;
    logic        dirRead;
    logic [17:0] addr;
    logic [17:0] wdata;
    logic        play;
    logic [17:0] startAddr;
    logic        busy;
    logic        rdValid;
    logic [17:0] rdata;
    modport ctrl (output start, dirRead, addr, wdata, play, startAddr,
                  input busy, rdValid, rdata);
    modport seq  (input start, dirRead, addr, wdata, play, startAddr,
                  output busy, rdValid, rdata);
endinterface
`default_nettype wire

// ### sram_sequencer.sv
// sram sequencer: single indirect accesses and continuous playback
// assumes: synchronous sram with one cycle of read latency
`timescale 1ns/1ps
`default_nettype none
module sram_sequencer (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // control side
    sram_if.seq              bus,
    // sram pins
    output logic [17:0]      sramAddr,
    output logic [17:0]      sramDout,
    output logic             sramDoutEn_n,
    output logic             sramWe_n,
    input  wire logic [17:0] sramDin,
    // playback word
    output logic [17:0]      playWord,
    output logic             playValid
);
    typedef struct packed {
        pmb_pkg::acc_state_t st;
        logic [17:0]         addr;
        logic                we_n;
        logic                rdValid;
        logic [17:0]         rdata;
        logic                playing;
        logic                fetched;
        logic [17:0]         word;
        logic                wordValid;
    } seq_t;
    seq_t s_r, s_nxt;

    // next address of the looping pattern
    function automatic logic [17:0] nextPlay(input logic [17:0] a, input logic [17:0] st);
        nextPlay = (a == pmb_pkg::PATTERN_END) ? st : a + 18'h00001;
    endfunction

    // access and playback sequencing
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdValid = 1'b0;
        s_nxt.we_n = 1'b1;
        s_nxt.fetched = 1'b0;
        if (bus.play) begin
            // no idle cycle at the wrap
            s_nxt.addr = s_r.playing ? nextPlay(s_r.addr, bus.startAddr) : bus.startAddr;
            s_nxt.playing = 1'b1;
            s_nxt.fetched = s_r.playing;
            s_nxt.st = pmb_pkg::ACC_IDLE;
        end else begin
            s_nxt.playing = 1'b0;
            case (s_r.st)
                pmb_pkg::ACC_IDLE: begin
                    if (bus.start) begin
                        s_nxt.addr = bus.addr;
                        s_nxt.we_n = bus.dirRead;
                        s_nxt.st = pmb_pkg::ACC_ISSUE;
                    end
                end
                pmb_pkg::ACC_ISSUE: s_nxt.st = s_r.we_n ? pmb_pkg::ACC_WAIT : pmb_pkg::ACC_IDLE;
                pmb_pkg::ACC_WAIT:  s_nxt.st = pmb_pkg::ACC_GRAB;
                pmb_pkg::ACC_GRAB: begin
                    s_nxt.rdata = sramDin;
                    s_nxt.rdValid = 1'b1;
                    s_nxt.st = pmb_pkg::ACC_IDLE;
                end
                default: s_nxt.st = pmb_pkg::ACC_IDLE;
            endcase
        end
        s_nxt.wordValid = s_r.fetched;
        if (s_r.fetched) begin
            s_nxt.word = sramDin;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.we_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sramAddr     = s_r.addr;
    assign sramDout     = bus.wdata;
    assign sramWe_n     = s_r.we_n;
    assign sramDoutEn_n = s_r.we_n;
    assign playWord     = s_r.word;
    assign playValid    = s_r.wordValid;
    assign bus.busy     = (s_r.st != pmb_pkg::ACC_IDLE);
    assign bus.rdValid  = s_r.rdValid;
    assign bus.rdata    = s_r.rdata;

    property p_wrap;
        @(posedge sys_clk) disable iff (!reset_n)
        (bus.play && s_r.playing && s_r.addr == pmb_pkg::PATTERN_END && $stable(bus.startAddr))
            |=> (s_r.addr == $past(bus.startAddr));
    endproperty
    a_wrap: assert property (p_wrap) else $error("playback did not wrap");

    property p_readgrab;
        @(posedge sys_clk) disable iff (!reset_n)
        (s_r.st == pmb_pkg::ACC_IDLE && bus.start && bus.dirRead && !bus.play)
            |-> ##4 bus.rdValid;
    endproperty
    a_readgrab: assert property (p_readgrab) else $error("read not captured");

    property p_write;
        @(posedge sys_clk) disable iff (!reset_n)
        (s_r.st == pmb_pkg::ACC_IDLE && bus.start && !bus.dirRead && !bus.play)
            |=> (!sramWe_n && sramAddr == $past(bus.addr));
    endproperty
    a_write: assert property (p_write) else $error("write not issued");
endmodule // sram_sequencer
`default_nettype wire

// ### pattern_memory_board_controller.sv
// top: host register port, clock select, pattern output to modulator
// assumes: all logic on the selected data clock fed back as sys_clk
`timescale 1ns/1ps
`default_nettype none
// Operation
// - write-data registers drive the 18-bit word onto sram data for writes
// - read-data registers capture sram data during a read access
// - address bits 17..0 drive sram address; bit 18 high means read
// - writing the upper address register starts one sram access
// - start-address registers hold where playback begins
// - playback wraps to start after the fixed end address
// - playback bit set streams sram words to the modulator bus
// - bits 15..0 are the I/Q word, bit 16 drives the sample strobe
// - bit 17 drives the transmit enable pin
// - group-three reads up to 7 go to modulator, above to controller
// - group-three writes 0..7 are forwarded to the modulator
// - status register shows fifo full, overflow, empty, lock, interrupt
// - two-bit field selects the data clock source or three-states it
// - data bus source is memory, ground or high impedance
// - stopping transmission switches the bus source to ground
// - board reset clears all; soft reset only the modulator
// - sram and playback run on the selected data clock
// - host writes an address register then transfers data by epp
// - playback repeats with no idle cycles between passes
module pattern_memory_board_controller (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // epp host port
    input  wire logic        addrStrobe_n,
    input  wire logic        dataStrobe_n,
    input  wire logic        hostWrite_n,
    input  wire logic [7:0]  hostDin,
    output logic [7:0]       hostDout,
    output logic             hostDoutEn_n,
    output logic             hostWait,
    // controls outside the register map
    input  wire logic        softReset,
    input  wire logic [1:0]  dinSourceSel,
    // pattern sram
    output logic [17:0]      sramAddr,
    output logic [17:0]      sramDout,
    output logic             sramDoutEn_n,
    output logic             sramWe_n,
    input  wire logic [17:0] sramDin,
    // modulator interface registers
    output logic [2:0]       modAddr,
    output logic [7:0]       modWdata,
    output logic             modWrite,
    output logic             modRead,
    input  wire logic [7:0]  modRdata,
    // modulator pins
    input  wire logic        fifo_full_flag,
    input  wire logic        fifo_overflow_flag,
    input  wire logic        fifo_empty_flag,
    input  wire logic        pll_lock_flag,
    input  wire logic        modIrq,
    output logic [15:0]      dinBus,
    output logic             dinBusEn_n,
    output logic             input_sample_strobe,
    output logic             transmit_enable_pin,
    output logic             modReset_n,
    // clock select
    output logic [1:0]       data_clock_select,
    output logic             sample_data_clockEn_n
);
    typedef struct packed {
        logic [2:0]        dsSync;
        logic [2:0]        asSync;
        logic [7:0]        epAddr;
        logic [17:0]       wdata;
        logic [18:0]       addr;
        logic [17:0]       startAddr;
        logic              play;
        logic [1:0]        clkSel;
        pmb_pkg::din_src_t src;
        logic [17:0]       rdata;
        logic              start;
        logic [7:0]        dout;
        logic              doutEn;
        logic [4:0]        status0;
        logic [4:0]        status;
        logic              modWr;
        logic              modRd;
        logic [7:0]        modWd;
        logic              softRst;
        logic [11:0]       pinSync0;
        logic [11:0]       pinSync1;
    } top_t;
    top_t t_r, t_nxt;

    sram_if sb ();
    logic [17:0] playWord;
    logic        playValid;
    logic        dsFall;
    logic        asFall;
    logic [1:0]  grp;
    logic [3:0]  ofs;
    logic [7:0]  hostByte;
    logic        writeSync_n;
    logic [1:0]  srcSel;

    // register address split into group and offset
    function automatic logic isGroup(input logic [7:0] a, input logic [1:0] g);
        isGroup = (a[5:4] == g);
    endfunction

    assign grp    = t_r.epAddr[5:4];
    assign ofs    = t_r.epAddr[3:0];
    assign dsFall = t_r.dsSync[2] & ~t_r.dsSync[1];
    assign asFall = t_r.asSync[2] & ~t_r.asSync[1];
    // host and control pins after two flip-flops
    assign hostByte    = t_r.pinSync1[7:0];
    assign writeSync_n = t_r.pinSync1[8];
    assign srcSel      = t_r.pinSync1[10:9];

    // host strobe handling and register file
    always_comb begin
        t_nxt = t_r;
        t_nxt.dsSync = {t_r.dsSync[1:0], dataStrobe_n};
        t_nxt.asSync = {t_r.asSync[1:0], addrStrobe_n};
        t_nxt.status0 = {modIrq, pll_lock_flag, fifo_empty_flag,
                         fifo_overflow_flag, fifo_full_flag};
        t_nxt.status = t_r.status0;
        t_nxt.start = 1'b0;
        t_nxt.modWr = 1'b0;
        t_nxt.modRd = 1'b0;
        t_nxt.pinSync0 = {softReset, dinSourceSel, hostWrite_n, hostDin};
        t_nxt.pinSync1 = t_r.pinSync0;
        t_nxt.softRst = t_r.pinSync1[11];
        if (t_r.dsSync[1] && t_r.asSync[1]) begin
            t_nxt.doutEn = 1'b0;
        end
        if (sb.rdValid) begin
            t_nxt.rdata = sb.rdata;
        end
        // address cycle latches target register
        if (asFall && !writeSync_n) begin
            t_nxt.epAddr = hostByte;
        end else if (asFall) begin
            t_nxt.dout = t_r.epAddr;
            t_nxt.doutEn = 1'b1;
        end
        // data cycle
        if (dsFall && !writeSync_n) begin
            if (isGroup(t_r.epAddr, pmb_pkg::GRP_CTRL)) begin
                case (ofs)
                    pmb_pkg::OFS_WLOW:  t_nxt.wdata[7:0]   = hostByte;
                    pmb_pkg::OFS_WMID:  t_nxt.wdata[15:8]  = hostByte;
                    pmb_pkg::OFS_WHIGH: t_nxt.wdata[17:16] = hostByte[1:0];
                    pmb_pkg::OFS_ALOW:  t_nxt.addr[7:0]    = hostByte;
                    pmb_pkg::OFS_AMID:  t_nxt.addr[15:8]   = hostByte;
                    pmb_pkg::OFS_AHIGH: begin
                        t_nxt.addr[18:16] = hostByte[2:0];
                        t_nxt.start = 1'b1;
                    end
                    pmb_pkg::OFS_SLOW:  t_nxt.startAddr[7:0]   = hostByte;
                    pmb_pkg::OFS_SMID:  t_nxt.startAddr[15:8]  = hostByte;
                    pmb_pkg::OFS_SHIGH: t_nxt.startAddr[17:16] = hostByte[1:0];
                    pmb_pkg::OFS_PCTRL: t_nxt.play = hostByte[pmb_pkg::PLAY_BIT];
                    default: ;
                endcase
            end else if (isGroup(t_r.epAddr, pmb_pkg::GRP_MOD)) begin
                if (ofs <= pmb_pkg::OFS_MODLIM) begin
                    t_nxt.modWr = 1'b1;
                    t_nxt.modWd = hostByte;
                end else if (ofs == pmb_pkg::OFS_CLKSEL) begin
                    t_nxt.clkSel = hostByte[1:0];
                end
            end
        end
        if (dsFall && writeSync_n) begin
            t_nxt.doutEn = 1'b1;
            t_nxt.dout = 8'h00;
            if (isGroup(t_r.epAddr, pmb_pkg::GRP_CTRL)) begin
                case (ofs)
                    pmb_pkg::OFS_WLOW:  t_nxt.dout = t_r.wdata[7:0];
                    pmb_pkg::OFS_WMID:  t_nxt.dout = t_r.wdata[15:8];
                    pmb_pkg::OFS_WHIGH: t_nxt.dout = {6'h00, t_r.wdata[17:16]};
                    pmb_pkg::OFS_RLOW:  t_nxt.dout = t_r.rdata[7:0];
                    pmb_pkg::OFS_RMID:  t_nxt.dout = t_r.rdata[15:8];
                    pmb_pkg::OFS_RHIGH: t_nxt.dout = {6'h00, t_r.rdata[17:16]};
                    pmb_pkg::OFS_ALOW:  t_nxt.dout = t_r.addr[7:0];
                    pmb_pkg::OFS_AMID:  t_nxt.dout = t_r.addr[15:8];
                    pmb_pkg::OFS_AHIGH: t_nxt.dout = {5'h00, t_r.addr[18:16]};
                    pmb_pkg::OFS_SLOW:  t_nxt.dout = t_r.startAddr[7:0];
                    pmb_pkg::OFS_SMID:  t_nxt.dout = t_r.startAddr[15:8];
                    pmb_pkg::OFS_SHIGH: t_nxt.dout = {6'h00, t_r.startAddr[17:16]};
                    pmb_pkg::OFS_PCTRL: t_nxt.dout = {7'h00, t_r.play};
                    default:            t_nxt.dout = 8'h00;
                endcase
            end else if (isGroup(t_r.epAddr, pmb_pkg::GRP_MOD)) begin
                if (ofs <= pmb_pkg::OFS_MODLIM) begin
                    t_nxt.modRd = 1'b1;
                    t_nxt.doutEn = 1'b0;
                end else if (ofs == pmb_pkg::OFS_STATUS) begin
                    t_nxt.dout = {3'h0, t_r.status};
                end else if (ofs == pmb_pkg::OFS_CLKSEL) begin
                    t_nxt.dout = {6'h00, t_r.clkSel};
                end
            end
        end
        // forwarded read answer lands one cycle after the request
        if (t_r.modRd) begin
            t_nxt.dout = modRdata;
            t_nxt.doutEn = 1'b1;
        end
        // bus source follows playback start and stop
        if (srcSel == 2'h2) begin
            t_nxt.src = pmb_pkg::DIN_HIZ;
        end else if (t_r.play && srcSel == 2'h0) begin
            t_nxt.src = pmb_pkg::DIN_MEMORY;
        end else begin
            t_nxt.src = pmb_pkg::DIN_GROUND;
        end
    end

    // state register, board reset clears everything
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            t_r        <= '0;
            t_r.dsSync <= 3'h7;
            t_r.asSync <= 3'h7;
            t_r.softRst <= 1'b1; // modulator held in reset too
            t_r.clkSel <= pmb_pkg::CLKSEL_RST;
            t_r.src    <= pmb_pkg::din_src_t'(pmb_pkg::DINSRC_RST);
        end else begin
            t_r <= t_nxt;
        end
    end

    // sram runs on this same data clock
    assign sb.start     = t_r.start;
    assign sb.dirRead   = t_r.addr[pmb_pkg::DIR_BIT];
    assign sb.addr      = t_r.addr[17:0];
    assign sb.wdata     = t_r.wdata;
    assign sb.play      = t_r.play;
    assign sb.startAddr = t_r.startAddr;

    sram_sequencer u_seq (
        .sys_clk      (sys_clk),
        .reset_n      (reset_n),
        .bus          (sb.seq),
        .sramAddr     (sramAddr),
        .sramDout     (sramDout),
        .sramDoutEn_n (sramDoutEn_n),
        .sramWe_n     (sramWe_n),
        .sramDin      (sramDin),
        .playWord     (playWord),
        .playValid    (playValid)
    );

    // modulator pins from the playback word
    logic memOn;
    assign memOn = (t_r.src == pmb_pkg::DIN_MEMORY) && playValid;
    assign dinBus              = memOn ? playWord[15:0] : 16'h0000;
    assign dinBusEn_n          = (t_r.src == pmb_pkg::DIN_HIZ);
    assign input_sample_strobe = memOn & playWord[pmb_pkg::STROBE_BIT];
    assign transmit_enable_pin = memOn & playWord[pmb_pkg::TRANSMIT_ENABLE_PIN_BIT];
    assign modReset_n          = ~t_r.softRst;
    assign data_clock_select   = t_r.clkSel;
    assign sample_data_clockEn_n = (t_r.clkSel == 2'h3);
    assign modAddr      = ofs[2:0];
    assign modWdata     = t_r.modWd;
    assign modWrite     = t_r.modWr;
    assign modRead      = t_r.modRd;
    assign hostDout     = t_r.dout;
    assign hostDoutEn_n = ~t_r.doutEn;
    assign hostWait     = ~(t_r.dsSync[1] & t_r.asSync[1]);

    property p_stopground;
        @(posedge sys_clk) disable iff (!reset_n)
        (!t_r.play && dinSourceSel == 2'h0) |=> (dinBus == 16'h0000);
    endproperty
    a_stopground: assert property (p_stopground) else $error("bus not grounded");

    property p_transmit_enable_pin;
        @(posedge sys_clk) disable iff (!reset_n)
        memOn |-> (transmit_enable_pin == playWord[17] && dinBus == playWord[15:0]);
    endproperty
    a_transmit_enable_pin: assert property (p_transmit_enable_pin) else $error("pattern bits misrouted");

    property p_start;
        @(posedge sys_clk) disable iff (!reset_n)
        (dsFall && !hostWrite_n && grp == pmb_pkg::GRP_CTRL && ofs == pmb_pkg::OFS_AHIGH)
            |=> t_r.start;
    endproperty
    a_start: assert property (p_start) else $error("access not started");

    property p_fwd;
        @(posedge sys_clk) disable iff (!reset_n)
        (dsFall && !hostWrite_n && grp == pmb_pkg::GRP_MOD && ofs <= pmb_pkg::OFS_MODLIM)
            |=> (modWrite && modWdata == $past(hostDin));
    endproperty
    a_fwd: assert property (p_fwd) else $error("write not forwarded");

    property p_clk;
        @(posedge sys_clk) disable iff (!reset_n)
        (dsFall && !hostWrite_n && grp == pmb_pkg::GRP_MOD && ofs == pmb_pkg::OFS_CLKSEL)
            |=> (data_clock_select == $past(hostDin[1:0]));
    endproperty
    a_clk: assert property (p_clk) else $error("clock select lost");
endmodule // pattern_memory_board_controller
`default_nettype wire

// ### pmb_host_model.sv
// epp host model: one address cycle, then one data cycle
// assumes: device raises hostWait while a strobe is seen low
`timescale 1ns/1ps
`default_nettype none
module pmb_host_model (
    // clock
    input  wire logic       sys_clk,
    // epp lines
    output logic            addrStrobe_n,
    output logic            dataStrobe_n,
    output logic            hostWrite_n,
    output logic [7:0]      hostDin,
    input  wire logic       hostWait,
    input  wire logic [7:0] hostDout
);
    int stuck = 0;
    initial begin
        addrStrobe_n = 1'b1;
        dataStrobe_n = 1'b1;
        hostWrite_n  = 1'b1;
        hostDin      = 8'h00;
    end
    // one strobe, held until wait rises, read data taken before release
    task automatic xfer(input logic isAddr, input logic isWr, input logic [7:0] d,
                        output logic [7:0] q);
        int n;
        @(negedge sys_clk);
        hostWrite_n  = !isWr;
        hostDin      = d;
        addrStrobe_n = !isAddr;
        dataStrobe_n = isAddr;
        for (n = 0; n < 8 && hostWait !== 1'b1; n++) @(negedge sys_clk);
        if (hostWait !== 1'b1) stuck++;
        repeat (3) @(negedge sys_clk);
        q = hostDout;
        addrStrobe_n = 1'b1;
        dataStrobe_n = 1'b1;
        hostDin      = ~d;  // released bus does not keep its old value
        for (n = 0; n < 8 && hostWait !== 1'b0; n++) @(negedge sys_clk);
        if (hostWait !== 1'b0) stuck++;
        repeat (3) @(negedge sys_clk);  // idle gap between strobes
    endtask
    // address cycle first, then the data cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, 1'b1, a, q);
        xfer(1'b0, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        xfer(1'b1, 1'b1, a, q);
        xfer(1'b0, 1'b0, 8'h00, q);
    endtask
endmodule // pmb_host_model
`default_nettype wire

// ### pattern_memory_board_controller_tb.sv
// testbench for the pattern memory board controller
// assumes: host model drives epp; sram and modulator modelled here
`timescale 1ns/1ps
`default_nettype none
module pattern_memory_board_controller_tb;
    typedef struct packed { logic [1:0] code; logic enN; } clkRow_t;
    logic        sys_clk      = 1'b0;
    logic        reset_n      = 1'b0;
    logic        softReset    = 1'b0;
    logic [1:0]  dinSourceSel = 2'h1;
    logic [4:0]  flags        = 5'h00;
    logic [17:0] sramDin      = 18'h00000;
    logic [10:0] modSeen      = 11'h000;
    logic [17:0] mem [0:16383];
    logic [7:0]  q;
    logic [17:0] a1, a2;
    int          i;
    int          num_errors   = 0;
    int          tests_run    = 0;
    wire         addrStrobe_n, dataStrobe_n, hostWrite_n, hostWait, hostDoutEn_n;
    wire  [7:0]  hostDin, hostDout, modWdata;
    wire  [17:0] sramAddr, sramDout;
    wire         sramDoutEn_n, sramWe_n, modWrite, modRead, dinBusEn_n, modReset_n;
    wire  [2:0]  modAddr;
    wire  [15:0] dinBus;
    wire         input_sample_strobe, transmit_enable_pin, sample_data_clockEn_n;
    wire  [1:0]  data_clock_select;
    wire  [7:0]  modRdata     = {5'h15, modAddr};
    clkRow_t     rows [4]     = '{'{2'h0, 1'b0}, '{2'h1, 1'b0}, '{2'h2, 1'b0}, '{2'h3, 1'b1}};
    logic [7:0]  rexp [3]     = '{8'h0F, 8'hB0, 8'h01};

    always #2.5 sys_clk = ~sys_clk;

    pattern_memory_board_controller i_pattern_memory_board_controller (
        .sys_clk, .reset_n, .addrStrobe_n, .dataStrobe_n, .hostWrite_n, .hostDin,
        .hostDout, .hostDoutEn_n, .hostWait, .softReset, .dinSourceSel,
        .sramAddr, .sramDout, .sramDoutEn_n, .sramWe_n, .sramDin,
        .modAddr, .modWdata, .modWrite, .modRead, .modRdata,
        .fifo_full_flag(flags[0]), .fifo_overflow_flag(flags[1]),
        .fifo_empty_flag(flags[2]), .pll_lock_flag(flags[3]), .modIrq(flags[4]),
        .dinBus, .dinBusEn_n, .input_sample_strobe, .transmit_enable_pin,
        .modReset_n, .data_clock_select, .sample_data_clockEn_n);
    pmb_host_model i_pmb_host_model (
        .sys_clk, .addrStrobe_n, .dataStrobe_n, .hostWrite_n, .hostDin,
        .hostWait, .hostDout);

    // synchronous sram, one cycle read latency; modulator write capture
    always @(posedge sys_clk) begin
        if (sramWe_n === 1'b0) begin
            mem[sramAddr[13:0]] <= sramDout;
            chk(sramDoutEn_n === 1'b0, "sram data not driven");
        end
        sramDin <= mem[sramAddr[13:0]];
        if (modWrite === 1'b1) modSeen <= {modAddr, modWdata};
        if (modRead === 1'b1) modSeen <= {modAddr, 8'h00};
    end

    function automatic logic [17:0] word(input logic [17:0] a);
        return {a[1:0], a[15:0] ^ 16'h5A5A};
    endfunction
    task automatic chk(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic finish_test;
        num_errors += i_pmb_host_model.stuck;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        for (i = 0; i < 16384; i++) mem[i] = word(18'(i));
        mem[14'h0777] = 18'h1B00F;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        chk(data_clock_select === 2'h0 && dinBus === 16'h0000, "reset state");
        // clock source codes, written and read back
        foreach (rows[k]) begin
            i_pmb_host_model.wr(8'h39, {6'h00, rows[k].code});
            chk(data_clock_select === rows[k].code, "clock select");
            chk(sample_data_clockEn_n === rows[k].enN, "clock enable");
            i_pmb_host_model.rd(8'h39, q);
            chk(q === {6'h00, rows[k].code}, "clock readback");
        end
        // indirect write at 0x01234, then read at 0x00777
        i_pmb_host_model.wr(8'h20, 8'hA5);
        i_pmb_host_model.wr(8'h21, 8'h3C);
        i_pmb_host_model.wr(8'h22, 8'h02);
        i_pmb_host_model.wr(8'h26, 8'h34);
        i_pmb_host_model.wr(8'h27, 8'h12);
        i_pmb_host_model.wr(8'h28, 8'h00);
        chk(sramDout === 18'h23CA5, "write data pins");
        chk(mem[14'h1234] === 18'h23CA5, "sram write");
        i_pmb_host_model.wr(8'h26, 8'h77);
        i_pmb_host_model.wr(8'h27, 8'h07);
        i_pmb_host_model.wr(8'h28, 8'h04);
        for (i = 0; i < 3; i++) begin
            i_pmb_host_model.rd(8'h23 + 8'(i), q);
            chk(q === rexp[i], "sram read");
        end
        i_pmb_host_model.wr(8'h2D, 8'hFF);
        i_pmb_host_model.rd(8'h2D, q);
        chk(q === 8'h00, "unmapped offset");
        // status pins, two patterns
        flags = 5'h16;
        i_pmb_host_model.rd(8'h38, q);
        chk(q[4:0] === 5'h16, "status a");
        flags = 5'h09;
        i_pmb_host_model.rd(8'h38, q);
        chk(q[4:0] === 5'h09, "status b");
        chk(hostDoutEn_n === 1'b1, "host bus not released");
        // modulator forwarding
        i_pmb_host_model.wr(8'h35, 8'hC3);
        chk(modSeen === {3'h5, 8'hC3}, "mod write");
        i_pmb_host_model.rd(8'h33, q);
        chk(q === 8'hAB, "mod read");
        chk(modSeen === {3'h3, 8'h00}, "mod read strobe");
        // soft reset leaves controller registers alone
        softReset = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(modReset_n === 1'b0 && data_clock_select === 2'h3, "soft reset");
        softReset = 1'b0;
        // playback from 0x03FFC wraps after the end address
        i_pmb_host_model.wr(8'h29, 8'hFC);
        i_pmb_host_model.wr(8'h2A, 8'h3F);
        i_pmb_host_model.wr(8'h2B, 8'h00);
        dinSourceSel = 2'h0;
        i_pmb_host_model.wr(8'h2C, 8'h01);
        @(negedge sys_clk) a2 = sramAddr;
        @(negedge sys_clk) a1 = sramAddr;
        for (i = 0; i < 16; i++) begin
            @(negedge sys_clk);
            chk(sramAddr === (a1 == 18'h03FFF ? 18'h03FFC : a1 + 18'h1), "play addr");
            chk({transmit_enable_pin, input_sample_strobe, dinBus} === word(a2), "word");
            chk(dinBusEn_n === 1'b0, "bus driven");
            a2 = a1;
            a1 = sramAddr;
        end
        dinSourceSel = 2'h1;
        repeat (4) @(negedge sys_clk);
        chk(dinBus === 16'h0000 && dinBusEn_n === 1'b0, "ground");
        dinSourceSel = 2'h0;
        i_pmb_host_model.wr(8'h2C, 8'h00);
        chk(dinBus === 16'h0000 && dinBusEn_n === 1'b0, "stop grounds bus");
        dinSourceSel = 2'h2;
        repeat (4) @(negedge sys_clk);
        chk(dinBusEn_n === 1'b1, "bus released");
        // board reset clears controller and modulator
        reset_n = 1'b0;
        @(negedge sys_clk);
        chk(data_clock_select === 2'h0 && modReset_n === 1'b0, "board reset");
        reset_n = 1'b1;
        finish_test();
    end
endmodule // pattern_memory_board_controller_tb
`default_nettype wire
